// ===== core/rcs_pkg.sv
// rcs_pkg: constants and carrier types of the reset-cause status block
// assumes one 100 MHz clock, 12-bit byte addresses and 8-bit register data
package rcs_pkg;

  // ----------------------------------------------------------------
  // bus geometry and register map
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W          = 12;
  localparam int unsigned DATA_W          = 8;
  localparam logic [11:0] RESET_CAUSE_OFF = 12'hff0;
  localparam logic [11:0] IRQ_STATUS_OFF  = 12'hff8;
  localparam logic [11:0] IRQ_MASK_OFF    = 12'hff9;

  // ----------------------------------------------------------------
  // reset-cause field positions and patterns
  // ----------------------------------------------------------------
  localparam int unsigned POR_BIT  = 7;
  localparam int unsigned WAKE_BIT = 6;
  localparam int unsigned WDT_BIT  = 5;
  localparam int unsigned EXT_BIT  = 4;
  localparam int unsigned RSVD_W   = 4;
  localparam logic [3:0]  RSVD_VAL = 4'h0;

  typedef struct packed {
    logic por;
    logic wake;
    logic wdt;
    logic external_pin_reset_flag;
  } rcs_flags_t;

  localparam rcs_flags_t FLAGS_POWER_ON = rcs_flags_t'(4'h8);
  localparam rcs_flags_t FLAGS_EXT_PIN  = rcs_flags_t'(4'h1);
  localparam rcs_flags_t FLAGS_WDT_RST  = rcs_flags_t'(4'h2);
  localparam rcs_flags_t FLAGS_PIN_WAKE = rcs_flags_t'(4'h4);
  localparam rcs_flags_t FLAGS_WDT_WAKE = rcs_flags_t'(4'h6);
  localparam rcs_flags_t FLAGS_CLEARED  = rcs_flags_t'(4'h0);

  // ----------------------------------------------------------------
  // interrupt status / mask layout
  // ----------------------------------------------------------------
  localparam int unsigned IRQ_W          = 4;
  localparam int unsigned IRQ_EXT_BIT    = 0;
  localparam int unsigned IRQ_DBG_BIT    = 1;
  localparam int unsigned IRQ_WDT_BIT    = 2;
  localparam int unsigned IRQ_WAKE_BIT   = 3;
  localparam logic [3:0]  IRQ_STATUS_RST = 4'h0;
  localparam logic [3:0]  IRQ_MASK_RST   = 4'h0;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS   = 10;
  localparam int unsigned RST_FILT_MIN_NS = 100;
  localparam int unsigned RST_FILT_CYC    =
    ((RST_FILT_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS) < 1 ? 1 :
    ((RST_FILT_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [11:0] addr;
    logic [7:0]  wdata;
    logic        wr;
    logic        rd;
  } rcs_bus_req_t;

  typedef struct packed {
    logic wdt_timeout;
    logic pin_wake;
    logic dbg_ctl_reset;
  } rcs_evt_t;

endpackage : rcs_pkg

// ===== core/rcs_pin_filter.sv
// rcs_pin_filter: glitch filter on an active-low reset pin
// assumes the pin is already synchronous to ref_clk
`timescale 1ns/1ns
`default_nettype none

module rcs_pin_filter #(
  parameter int unsigned MIN_CYC = rcs_pkg::RST_FILT_CYC
) (
  input  wire logic ref_clk,
  input  wire logic arst_n,
  input  wire logic pin_n,
  output logic      low_pulse,
  output logic      low_level
);

  localparam int unsigned CNT_W = $clog2(MIN_CYC + 1);

  typedef enum logic [2:0] {
    RCS_PF_HIGH  = 3'b001,
    RCS_PF_COUNT = 3'b010,
    RCS_PF_LOW   = 3'b100
  } rcs_pf_state_t;

  typedef struct packed {
    rcs_pf_state_t    st;
    logic [CNT_W-1:0] cnt;
    logic             pulse;
  } rcs_pf_t;

  rcs_pf_t q;
  rcs_pf_t d;

  // ----------------------------------------------------------------
  // low must persist MIN_CYC samples before it counts as a reset
  // ----------------------------------------------------------------
  always_comb begin
    d       = q;
    d.pulse = 1'b0;
    unique case (q.st)
      RCS_PF_HIGH: begin
        if (!pin_n) begin
          if (MIN_CYC <= 1) begin
            d.pulse = 1'b1; // [RQ14]
            d.st    = RCS_PF_LOW;
          end else begin
            d.cnt = CNT_W'(1);
            d.st  = RCS_PF_COUNT;
          end
        end
      end
      RCS_PF_COUNT: begin
        if (pin_n) begin
          d.st = RCS_PF_HIGH; // short pulse dropped [RQ14]
        end else if ((q.cnt + CNT_W'(1)) >= CNT_W'(MIN_CYC)) begin
          d.pulse = 1'b1; // [RQ14]
          d.st    = RCS_PF_LOW;
        end else begin
          d.cnt = q.cnt + CNT_W'(1);
        end
      end
      RCS_PF_LOW: begin
        if (pin_n) begin
          d.st = RCS_PF_HIGH;
        end
      end
      default: begin
        d.st = RCS_PF_HIGH;
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      q.st    <= RCS_PF_HIGH;
      q.cnt   <= '0;
      q.pulse <= 1'b0;
    end else begin
      q <= d;
    end
  end

  assign low_pulse = q.pulse;
  assign low_level = (q.st == RCS_PF_LOW);

endmodule // rcs_pin_filter

`default_nettype wire

// ===== core/rcs_irq_ctl.sv
// rcs_irq_ctl: sticky event status, mask and one level interrupt
// assumes strobes are single-cycle and decoded by the caller
`timescale 1ns/1ns
`default_nettype none

module rcs_irq_ctl #(
  parameter int unsigned W = rcs_pkg::IRQ_W
) (
  input  wire logic         ref_clk,
  input  wire logic         arst_n,
  input  wire logic [W-1:0] evt,
  input  wire logic         clr_we,
  input  wire logic [W-1:0] clr_data,
  input  wire logic         mask_we,
  input  wire logic [W-1:0] mask_data,
  output logic      [W-1:0] status,
  output logic      [W-1:0] mask,
  output logic              irq
);

  typedef struct packed {
    logic [W-1:0] status;
    logic [W-1:0] mask;
  } rcs_irq_t;

  rcs_irq_t q;
  rcs_irq_t d;

  // ----------------------------------------------------------------
  // write-one-to-clear; a same-cycle event keeps its bit
  // ----------------------------------------------------------------
  always_comb begin
    d = q;
    if (clr_we) begin
      d.status = q.status & ~clr_data;
    end
    d.status = d.status | evt;
    if (mask_we) begin
      d.mask = mask_data;
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      q.status <= W'(rcs_pkg::IRQ_STATUS_RST);
      q.mask   <= W'(rcs_pkg::IRQ_MASK_RST);
    end else begin
      q <= d;
    end
  end

  assign status = q.status;
  assign mask   = q.mask;
  // combinational from flops only, no extra latency
  assign irq    = |(q.status & q.mask);

endmodule // rcs_irq_ctl

`default_nettype wire

// ===== core/rcs_top.sv
// rcs_top: reset-cause status register, watchdog-control write port,
// reset-pin filter and event interrupt
// assumes arst_n is the power-on reset only; other resets arrive as inputs
// and do not clear this block
//
// Contract
// [RQ1] read-only register holds latest reset cause, stop wake and watchdog timeout
// [RQ2] any read of the cause register clears its four flags after returning them
// [RQ3] cause register shares its address with the write-only watchdog control
// [RQ4] power-on flag set by power-on reset, cleared by watchdog or stop wake
// [RQ5] wake flag set by stop wake, cleared by power-on or non-stop watchdog
// [RQ6] wake plus watchdog flag means the wake came from a watchdog timeout
// [RQ7] watchdog flag set by timeout, cleared by power-on or pin-change wake
// [RQ8] software reads the cause register before clearing the watchdog interrupt
// [RQ9] external flag set by reset pin, cleared by power-on or pin-change wake
// [RQ10] bits three to zero reset to zero and always read zero
// [RQ11] power-on gives 1000, reset pin gives 0001, watchdog reset gives 0010
// [RQ12] debugger control reset and debug-pin stop reset each give 1000
// [RQ13] pin-change wake gives 0100, watchdog wake gives 0110
// [RQ14] reset pin low in stop resets the system, short glitches ignored
// [RQ15] a flag-setting event beats a clearing read in the same cycle
`timescale 1ns/1ns
`default_nettype none

module rcs_top #(
  parameter int unsigned FILT_CYC = rcs_pkg::RST_FILT_CYC
) (
  input  wire logic                 ref_clk,
  input  wire logic                 arst_n,
  input  wire rcs_pkg::rcs_bus_req_t bus_req,
  output logic [7:0]                rd_data,
  input  wire rcs_pkg::rcs_evt_t    evt,
  input  wire logic                 in_stop,
  input  wire logic                 ext_rst_pin_n,
  input  wire logic                 debug_pin_n,
  output logic                      wdt_ctl_we,
  output logic [7:0]                wdt_ctl_data,
  output logic                      sys_rst_req,
  output logic                      irq
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    rcs_pkg::rcs_flags_t flags;
    logic [7:0]          rd_data;
    logic                wdt_we;
    logic [7:0]          wdt_data;
    logic                sys_rst;
    logic                dbg_pin_prev_n;
  } rcs_top_st_t;

  rcs_top_st_t q;
  rcs_top_st_t d;

  logic                      ext_pulse;
  logic [rcs_pkg::IRQ_W-1:0] irq_evt;
  logic [rcs_pkg::IRQ_W-1:0] irq_status;
  logic [rcs_pkg::IRQ_W-1:0] irq_mask;
  logic                      dbg_pin_evt;
  logic                      wdt_evt;
  logic                      wake_evt;
  logic                      hit_cause;
  logic                      hit_status;
  logic                      hit_mask;

  function automatic logic addr_hit(input logic [11:0] a, input logic [11:0] off);
    addr_hit = (a == off);
  endfunction

  // ----------------------------------------------------------------
  // reset pin filter
  // ----------------------------------------------------------------
  rcs_pin_filter #(
    .MIN_CYC   (FILT_CYC)
  ) u_pin_filter (
    .ref_clk   (ref_clk),
    .arst_n    (arst_n),
    .pin_n     (ext_rst_pin_n),
    .low_pulse (ext_pulse),
    .low_level ()
  );

  // ----------------------------------------------------------------
  // event qualification
  // ----------------------------------------------------------------
  // debug pin only matters as a falling edge while stopped
  assign dbg_pin_evt = in_stop && q.dbg_pin_prev_n && !debug_pin_n;
  assign wdt_evt     = evt.wdt_timeout;
  // pin-change wake has no meaning outside the stop state
  assign wake_evt    = evt.pin_wake && in_stop;

  assign hit_cause  = addr_hit(bus_req.addr, rcs_pkg::RESET_CAUSE_OFF);
  assign hit_status = addr_hit(bus_req.addr, rcs_pkg::IRQ_STATUS_OFF);
  assign hit_mask   = addr_hit(bus_req.addr, rcs_pkg::IRQ_MASK_OFF);

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    d                = q;
    d.wdt_we         = 1'b0;
    d.sys_rst        = 1'b0;
    d.rd_data        = 8'h00;
    d.dbg_pin_prev_n = debug_pin_n;

    // read path: answer stands only in the cycle after the strobe
    if (bus_req.rd) begin
      if (hit_cause) begin
        d.rd_data = {q.flags, rcs_pkg::RSVD_VAL}; // [RQ1] [RQ10]
        d.flags   = rcs_pkg::FLAGS_CLEARED; // [RQ2]
      end else if (hit_status) begin
        d.rd_data = {4'h0, irq_status};
      end else if (hit_mask) begin
        d.rd_data = {4'h0, irq_mask};
      end
    end

    // writes at the cause address go to watchdog control
    if (bus_req.wr && hit_cause) begin
      d.wdt_we   = 1'b1; // [RQ3]
      d.wdt_data = bus_req.wdata; // [RQ3]
    end

    // events override a same-cycle read clear; pin reset outranks the rest
    if (ext_pulse) begin
      d.flags   = rcs_pkg::FLAGS_EXT_PIN; // [RQ9] [RQ11] [RQ15]
      d.sys_rst = 1'b1; // [RQ14]
    end else if (evt.dbg_ctl_reset || dbg_pin_evt) begin
      d.flags   = rcs_pkg::FLAGS_POWER_ON; // [RQ12] [RQ15]
      d.sys_rst = 1'b1;
    end else if (wdt_evt) begin
      if (in_stop) begin
        d.flags = rcs_pkg::FLAGS_WDT_WAKE; // [RQ4] [RQ6] [RQ13] [RQ15]
      end else begin
        d.flags = rcs_pkg::FLAGS_WDT_RST; // [RQ5] [RQ7] [RQ11] [RQ15]
      end
    end else if (wake_evt) begin
      d.flags = rcs_pkg::FLAGS_PIN_WAKE; // [RQ4] [RQ7] [RQ9] [RQ13] [RQ15]
    end
  end

  // ----------------------------------------------------------------
  // registers; arst_n is power-on so flags come up as 1000
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      q.flags          <= rcs_pkg::FLAGS_POWER_ON; // [RQ4] [RQ11]
      q.rd_data        <= 8'h00;
      q.wdt_we         <= 1'b0;
      q.wdt_data       <= 8'h00;
      q.sys_rst        <= 1'b0;
      q.dbg_pin_prev_n <= 1'b1;
    end else begin
      q <= d;
    end
  end

  // ----------------------------------------------------------------
  // interrupt
  // ----------------------------------------------------------------
  always_comb begin
    irq_evt                            = '0;
    irq_evt[rcs_pkg::IRQ_EXT_BIT]  = ext_pulse;
    irq_evt[rcs_pkg::IRQ_DBG_BIT]  = evt.dbg_ctl_reset || dbg_pin_evt;
    irq_evt[rcs_pkg::IRQ_WDT_BIT]  = wdt_evt;
    irq_evt[rcs_pkg::IRQ_WAKE_BIT] = wake_evt;
  end

  rcs_irq_ctl #(
    .W         (rcs_pkg::IRQ_W)
  ) u_irq_ctl (
    .ref_clk   (ref_clk),
    .arst_n    (arst_n),
    .evt       (irq_evt),
    .clr_we    (bus_req.wr && hit_status),
    .clr_data  (bus_req.wdata[rcs_pkg::IRQ_W-1:0]),
    .mask_we   (bus_req.wr && hit_mask),
    .mask_data (bus_req.wdata[rcs_pkg::IRQ_W-1:0]),
    .status    (irq_status),
    .mask      (irq_mask),
    .irq       (irq)
  );

  assign rd_data      = q.rd_data;
  assign wdt_ctl_we   = q.wdt_we;
  assign wdt_ctl_data = q.wdt_data;
  assign sys_rst_req  = q.sys_rst;

endmodule // rcs_top

`default_nettype wire

// ===== dv/rcs_top_sva.sv
// rcs_top_sva: port-level checks of the reset-cause block
// assumes one clock domain; pin-driven flags need both pins high around a read
`timescale 1ns/1ns
`default_nettype none

module rcs_sva #(
  parameter int unsigned FILT_CYC = rcs_pkg::RST_FILT_CYC
) (
  input wire logic                  ref_clk,
  input wire logic                  arst_n,
  input wire rcs_pkg::rcs_bus_req_t bus_req,
  input wire logic [7:0]            rd_data,
  input wire rcs_pkg::rcs_evt_t     evt,
  input wire logic                  in_stop,
  input wire logic                  ext_rst_pin_n,
  input wire logic                  debug_pin_n,
  input wire logic                  wdt_ctl_we,
  input wire logic [7:0]            wdt_ctl_data,
  input wire logic                  sys_rst_req,
  input wire logic                  irq
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!arst_n);

  wire cause_rd = bus_req.rd && bus_req.addr == 12'hff0;
  wire pins_hi  = ext_rst_pin_n && debug_pin_n;
  wire calm     = pins_hi && evt == 3'h0;

  // ------------------------------------------------------------
  // sequences
  // ------------------------------------------------------------
  // two quiet pin cycles first, so no filtered pulse is still in flight
  sequence settled;
    pins_hi [*2];
  endsequence
  sequence calm_read;
    cause_rd && calm;
  endsequence
  property pat_p(logic [2:0] ev, logic stop, logic [7:0] val);
    settled ##1 (evt == ev && in_stop == stop && pins_hi) ##1 calm_read |=> rd_data == val;
  endproperty

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  rsvd_zero_a: assert property (cause_rd |=> rd_data[3:0] == 4'h0)
    else $error("reserved bits read nonzero");
  wr_fwd_a: assert property (bus_req.wr && bus_req.addr == 12'hff0
    |=> wdt_ctl_we && wdt_ctl_data == $past(bus_req.wdata)) else $error("write not forwarded");
  no_stray_we_a: assert property (!(bus_req.wr && bus_req.addr == 12'hff0) |=> !wdt_ctl_we)
    else $error("stray watchdog write");
  rd_idle_a: assert property (!bus_req.rd |=> rd_data == 8'h00)
    else $error("read data outside read cycle");
  read_clear_a: assert property (settled ##1 calm_read ##1 calm ##1 calm_read |=> rd_data == 8'h00)
    else $error("flags survive a read");
  dbg_rst_a: assert property (evt.dbg_ctl_reset |=> sys_rst_req)
    else $error("no system reset on debugger request");
  wdt_rst_a: assert property (pat_p(3'h4, 1'b0, 8'h20))
    else $error("watchdog reset pattern");
  wdt_wake_a: assert property (pat_p(3'h4, 1'b1, 8'h60))
    else $error("watchdog wake pattern");
  pin_wake_a: assert property (pat_p(3'h2, 1'b1, 8'h40))
    else $error("pin wake pattern");
  dbg_ctl_a: assert property (pat_p(3'h1, 1'b0, 8'h80))
    else $error("debugger reset pattern");
  set_wins_a: assert property (settled ##1 (evt == 3'h4 && !in_stop && pins_hi && cause_rd)
    ##1 calm_read |=> rd_data == 8'h20) else $error("read clear beat an event");
endmodule // rcs_sva

bind rcs_top rcs_sva #(.FILT_CYC(FILT_CYC)) u_sva (
  .ref_clk(ref_clk), .arst_n(arst_n), .bus_req(bus_req), .rd_data(rd_data), .evt(evt),
  .in_stop(in_stop), .ext_rst_pin_n(ext_rst_pin_n), .debug_pin_n(debug_pin_n),
  .wdt_ctl_we(wdt_ctl_we), .wdt_ctl_data(wdt_ctl_data), .sys_rst_req(sys_rst_req), .irq(irq)
);

`default_nettype wire

// ===== dv/rcs_top_test.sv
// rcs_top_test: self-checking bench of the reset-cause block
// assumes the filter is shortened to two samples
`timescale 1ns/1ns
`default_nettype none

module rcs_top_test;
  rcs_pkg::rcs_bus_req_t bus_req;
  rcs_pkg::rcs_evt_t     evt;
  logic                  ref_clk;
  logic                  arst_n;
  logic                  in_stop;
  logic                  ext_rst_pin_n;
  logic                  debug_pin_n;
  logic [7:0]            rd_data;
  logic [7:0]            wdt_ctl_data;
  logic                  wdt_ctl_we;
  logic                  sys_rst_req;
  logic                  irq;
  int                    error_cnt = 0;
  int                    tests_run = 0;

  rcs_top #(.FILT_CYC(2)) u_dut (
    .ref_clk(ref_clk), .arst_n(arst_n), .bus_req(bus_req), .rd_data(rd_data), .evt(evt),
    .in_stop(in_stop), .ext_rst_pin_n(ext_rst_pin_n), .debug_pin_n(debug_pin_n),
    .wdt_ctl_we(wdt_ctl_we), .wdt_ctl_data(wdt_ctl_data), .sys_rst_req(sys_rst_req), .irq(irq)
  );

  // ------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge ref_clk);
    bus_req.wr <= 1'b0;
    #1;
  endtask

  task automatic rd(input logic [11:0] a, input logic [7:0] exp);
    @(posedge ref_clk);
    bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge ref_clk);
    bus_req.rd <= 1'b0;
    #1 chk(rd_data, exp);
  endtask

  // event and pin lows start together; cause read at rd_at, -1 reads with the event and again
  // right after, checking the second read so a same-cycle set must survive the clear
  task automatic stim(input logic [2:0] e, input logic stop, input int ext_lo, input int dbg_lo,
                      input int rd_at, input logic [7:0] exp_rd, input int exp_sr);
    int sr;
    sr = 0;
    @(posedge ref_clk);
    evt <= e;
    in_stop <= stop;
    ext_rst_pin_n <= (ext_lo == 0);
    debug_pin_n <= (dbg_lo == 0);
    bus_req <= '{addr: 12'hff0, wdata: 8'h00, wr: 1'b0, rd: rd_at < 0};
    for (int i = 0; i < 10; i++) begin
      @(posedge ref_clk);
      evt <= 3'h0;
      bus_req.rd <= (i == rd_at || i + rd_at == -1);
      if (i + 1 >= ext_lo) ext_rst_pin_n <= 1'b1;
      if (i + 1 >= dbg_lo) debug_pin_n <= 1'b1;
      #1;
      sr += sys_rst_req;
      if (i == (rd_at < 0 ? 1 : rd_at + 1)) chk(rd_data, exp_rd);
    end
    chk(8'(sr), 8'(exp_sr));
  endtask

  task automatic results;
    $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // ------------------------------------------------------------
  // sequence
  // ------------------------------------------------------------
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  initial begin
    repeat (5000) @(posedge ref_clk);
    error_cnt++;
    $display("[FAIL] %0t run did not finish in time", $time);
    results();
  end

  initial begin
    arst_n = 1'b0;
    bus_req = '0;
    evt = '0;
    in_stop = 1'b0;
    ext_rst_pin_n = 1'b1;
    debug_pin_n = 1'b1;
    repeat (8) @(posedge ref_clk);
    arst_n <= 1'b1;
    // one idle cycle so the read-clear check sees two quiet samples first
    @(posedge ref_clk);
    rd(12'hff0, 8'h80);
    rd(12'hff0, 8'h00);
    rd(12'hff8, 8'h00);
    rd(12'hff9, 8'h00);
    rd(12'h123, 8'h00);
    wr(12'hff0, 8'ha5);
    chk({7'h00, wdt_ctl_we}, 8'h01);
    chk(wdt_ctl_data, 8'ha5);
    rd(12'hff0, 8'h00);
    stim(3'h1, 1'b0, 0, 0, 0, 8'h80, 1);
    stim(3'h1, 1'b0, 0, 0, 99, 8'h00, 1);
    stim(3'h4, 1'b0, 0, 0, 0, 8'h20, 0);
    stim(3'h4, 1'b0, 0, 0, 99, 8'h00, 0);
    stim(3'h2, 1'b0, 0, 0, 0, 8'h20, 0);
    stim(3'h4, 1'b1, 0, 0, 0, 8'h60, 0);
    stim(3'h4, 1'b1, 0, 0, 99, 8'h00, 0);
    stim(3'h2, 1'b1, 0, 0, 0, 8'h40, 0);
    stim(3'h2, 1'b1, 0, 0, 99, 8'h00, 0);
    stim(3'h4, 1'b0, 0, 0, 0, 8'h20, 0);
    chk({7'h00, irq}, 8'h00);
    rd(12'hff8, 8'h0e);
    wr(12'hff9, 8'h04);
    chk({7'h00, irq}, 8'h01);
    rd(12'hff0, 8'h00);
    wr(12'hff8, 8'h04);
    chk({7'h00, irq}, 8'h00);
    rd(12'hff8, 8'h0a);
    stim(3'h0, 1'b1, 1, 0, 6, 8'h00, 0);
    stim(3'h0, 1'b1, 2, 0, 6, 8'h10, 1);
    stim(3'h0, 1'b1, 0, 2, 6, 8'h80, 1);
    stim(3'h0, 1'b0, 0, 2, 6, 8'h00, 0);
    stim(3'h4, 1'b0, 0, 0, -1, 8'h20, 0);
    results();
  end
endmodule // rcs_top_test

`default_nettype wire
